// File: hdl/dadc_top.sv
`include "dadc_defs.svh"

// ==========================================
// sample buffer
module dadc_fifo #(
    parameter int W     = 20,
    parameter int DEPTH = `DADC_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    logic          push;
    logic          pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // flags are kept as flops so that ready leaves the block unbuffered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else if (ce) begin
            count     <= next_count;
            in_ready  <= next_count != (AW+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// Overview of operation
// - each channel outputs latched words five encode cycles after sampling, after rising edges
// - format select high gives two's complement, low gives offset binary
// - powered-down channels release their output drivers to high impedance
// - one option stops both channels, another stops only channel B
// - data is valid again only ten encode cycles after leaving power-down
// - data align delays channel B output by half an encode period
// - with antiphase clocks and align, B data appears at clock A rising edge
// - shared clock with align: B updates in antiphase to A
// - shared clock without align: both outputs update on the same rising edge
module dadc_top #(
    parameter int W     = `DADC_WORD_W,
    parameter int LAT   = `DADC_PIPE_LAT,
    parameter int DEPTH = `DADC_FIFO_DEPTH
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    input  wire logic                    enc_a,
    input  wire logic                    enc_b,
    input  wire logic                    format_select,
    input  wire logic                    mode_pin_one,
    input  wire logic                    mode_pin_two,
    input  wire logic [W-1:0]            smp_a_data,
    input  wire logic                    smp_a_valid,
    output logic                         smp_a_ready,
    input  wire logic [W-1:0]            smp_b_data,
    input  wire logic                    smp_b_valid,
    output logic                         smp_b_ready,
    output logic [W-1:0]                 dout_a,
    output logic                         dout_a_oe_n,
    output logic [W-1:0]                 dout_b,
    output logic                         dout_b_oe_n,
    output logic                         clkout_a,
    output logic                         clkout_b,
    output logic                         valid_a,
    output logic                         valid_b,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`DADC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr
);
    import dadc_pkg::*;

    if (LAT < 1 || LAT > 14 || W < 2) begin : g_chk
        $error("latency must be 1..14 and word width at least 2");
    end

    localparam logic [3:0] REC = 4'(`DADC_RECOVER_CYC);

    // ==========================================
    // pin synchronisers
    logic [4:0]            pin_s1;
    logic [4:0]            pin_s2;
    logic [1:0]            enc_d;
    logic [1:0]            rise;
    logic [1:0]            fall;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            enc_d  <= '0;
        end else if (ce) begin
            pin_s1 <= {format_select, mode_pin_two, mode_pin_one, enc_b, enc_a};
            pin_s2 <= pin_s1;
            enc_d  <= pin_s2[1:0];
        end
    end

    assign rise = pin_s2[1:0] & ~enc_d;
    assign fall = ~pin_s2[1:0] & enc_d;

    // ==========================================
    // mode and format selection
    logic [`DADC_CTRL_W-1:0] ctrl;
    dadc_mode_t              mode;
    logic                    fmt_tc;
    logic [1:0]              run;
    logic                    align;

    function automatic dadc_mode_t decode_mode(input logic one, input logic two);
        dadc_mode_t m;
        unique case ({one, two})
            2'b10: m = MODE_NORMAL;
            2'b11: m = MODE_ALIGN;
            2'b01: m = MODE_PD_B;
            2'b00: m = MODE_PD_ALL;
        endcase
        return m;
    endfunction

    function automatic logic [W-1:0] fmt(input logic [W-1:0] w, input logic tc);
        return w ^ {tc, {(W-1){1'b0}}};
    endfunction

    // software may override the pins; pins are the default after reset
    // pin option select
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode   <= MODE_NORMAL;
            fmt_tc <= 1'b0;
        end else if (ce) begin
            if (ctrl[`DADC_CTRL_OVR_BIT]) begin
                mode   <= decode_mode(ctrl[`DADC_CTRL_M1_BIT], ctrl[`DADC_CTRL_M2_BIT]);
                fmt_tc <= ctrl[`DADC_CTRL_FMT_BIT];
            end else begin
                mode   <= decode_mode(pin_s2[2], pin_s2[3]);
                fmt_tc <= pin_s2[4];
            end
        end
    end

    assign run[0] = mode != MODE_PD_ALL;
    assign run[1] = mode == MODE_NORMAL || mode == MODE_ALIGN;
    assign align  = mode == MODE_ALIGN;

    // ==========================================
    // per-channel pipeline
    logic [W-1:0] in_data  [2];
    logic [1:0]   in_valid;
    logic [1:0]   in_ready;
    logic [W-1:0] fifo_q   [2];
    logic [1:0]   fifo_v;
    logic [W-1:0] pipe     [2][LAT];
    logic [W-1:0] stage    [2];
    logic [W-1:0] dout     [2];
    logic [1:0]   oe_n;
    logic [1:0]   clk_o;
    logic [1:0]   vld;
    logic [3:0]   rec_cnt  [2];

    assign in_data[0] = smp_a_data;
    assign in_data[1] = smp_b_data;
    assign in_valid   = {smp_b_valid, smp_a_valid};

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        // halted channel stops popping, so the buffer fills and stalls the source
        dadc_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
            .clk       (clk),
            .rstn      (rstn),
            .ce        (ce),
            .in_data   (in_data[ch]),
            .in_valid  (in_valid[ch]),
            .in_ready  (in_ready[ch]),
            .out_data  (fifo_q[ch]),
            .out_valid (fifo_v[ch]),
            .out_ready (rise[ch] && run[ch])
        );

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                for (int i = 0; i < LAT; i++) begin
                    pipe[ch][i] <= '0;
                end
                stage[ch] <= '0;
            end else if (ce && rise[ch] && run[ch]) begin
                if (fifo_v[ch]) begin
                    pipe[ch][0] <= fifo_q[ch];
                end
                for (int i = 1; i < LAT; i++) begin
                    pipe[ch][i] <= pipe[ch][i-1];
                end
                stage[ch] <= pipe[ch][LAT-1];
            end
        end

        // channel b in align mode loads on the falling encode edge from stage
        // half-cycle align
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                dout[ch] <= '0;
            end else if (ce) begin
                if (!run[ch]) begin
                    dout[ch] <= '0;
                end else if (ch == 1 && align) begin
                    if (fall[ch]) begin
                        dout[ch] <= fmt(stage[ch], fmt_tc);
                    end
                end else if (rise[ch]) begin
                    dout[ch] <= fmt(pipe[ch][LAT-1], fmt_tc);
                end
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                oe_n[ch]  <= 1'b0;
                clk_o[ch] <= 1'b0;
            end else if (ce) begin
                oe_n[ch]  <= !run[ch];
                clk_o[ch] <= pin_s2[ch];
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                rec_cnt[ch] <= REC;
                vld[ch]     <= 1'b0;
            end else if (ce) begin
                if (!run[ch]) begin
                    rec_cnt[ch] <= REC;
                end else if (rise[ch] && rec_cnt[ch] != 4'h0) begin
                    rec_cnt[ch] <= rec_cnt[ch] - 4'h1;
                end
                vld[ch] <= run[ch] && rec_cnt[ch] == 4'h0;
            end
        end
    end

    assign smp_a_ready = in_ready[0];
    assign smp_b_ready = in_ready[1];
    assign dout_a      = dout[0];
    assign dout_b      = dout[1];
    assign dout_a_oe_n = oe_n[0];
    assign dout_b_oe_n = oe_n[1];
    assign clkout_a    = clk_o[0];
    assign clkout_b    = clk_o[1];
    assign valid_a     = vld[0];
    assign valid_b     = vld[1];

    // ==========================================
    // apb slave, one wait state on every access
    logic        acc;
    logic        hit;
    logic [31:0] rd_val;

    assign acc = psel && penable;
    assign hit = paddr == `DADC_CTRL_OFS || (paddr == `DADC_STAT_OFS && !pwrite);

    always_comb begin
        rd_val = 32'h0;
        if (paddr == `DADC_CTRL_OFS) begin
            rd_val[`DADC_CTRL_W-1:0] = ctrl;
        end else if (paddr == `DADC_STAT_OFS) begin
            rd_val[9:0] = {fmt_tc, align, fifo_v, vld, run, mode};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (ce) begin
            if (acc && !pready) begin
                pready  <= 1'b1;
                pslverr <= !hit;
                prdata  <= pwrite ? 32'h0 : rd_val;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `DADC_CTRL_RST;
        end else if (ce && acc && pready && pwrite && paddr == `DADC_CTRL_OFS) begin
            ctrl <= pwdata[`DADC_CTRL_W-1:0];
        end
    end

    // ==========================================
    // checks
    logic [3:0]   tk_cnt;
    logic [W-1:0] tk_val;
    logic [3:0]   on_cnt;

    // follows one sample of channel a through the pipeline
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tk_cnt <= 4'h0;
            tk_val <= '0;
        end else if (ce && rise[0]) begin
            if (!run[0]) begin
                tk_cnt <= 4'h0;
            end else if (tk_cnt == 4'h0 && fifo_v[0]) begin
                tk_cnt <= 4'h1;
                tk_val <= fifo_q[0];
            end else if (tk_cnt != 4'h0 && tk_cnt < 4'(LAT)) begin
                tk_cnt <= tk_cnt + 4'h1;
            end else begin
                tk_cnt <= 4'h0;
            end
        end
    end

    // encode rises of channel b since it was last powered down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_cnt <= 4'h0;
        end else if (ce) begin
            if (!run[1]) begin
                on_cnt <= 4'h0;
            end else if (rise[1] && on_cnt != 4'hf) begin
                on_cnt <= on_cnt + 4'h1;
            end
        end
    end

    pipe_latency_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && rise[0] && run[0] && tk_cnt == 4'(LAT) |=> dout_a == fmt(tk_val, $past(fmt_tc)))
        else $error("channel a word not out after pipeline latency");

    a_edge_only_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $changed(dout_a) && !dout_a_oe_n |-> $past(rise[0]))
        else $error("channel a changed without a rising encode edge");

    out_coding_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && rise[0] && run[0] |=> dout_a[W-1] == ($past(pipe[0][LAT-1][W-1]) ^ $past(fmt_tc)))
        else $error("output coding does not follow format select");

    pd_hiz_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && !run[0] |=> dout_a_oe_n && dout_b_oe_n)
        else $error("drivers enabled during full power-down");

    pd_b_only_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && mode == MODE_PD_B |=> !dout_a_oe_n && dout_b_oe_n)
        else $error("channel b power-down affects the wrong channel");

    recovery_wait_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(valid_b) |-> on_cnt >= REC)
        else $error("channel b valid before recovery cycles elapsed");

    align_fall_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(align) && $changed(dout_b) && !dout_b_oe_n |-> $past(fall[1]))
        else $error("aligned channel b changed off the falling edge");

    no_align_rise_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !$past(align) && $changed(dout_b) && !dout_b_oe_n |-> $past(rise[1]))
        else $error("channel b changed off the rising edge without align");
endmodule

// File: pkg/dadc_defs.svh
`ifndef DADC_DEFS_SVH
`define DADC_DEFS_SVH

// ==========================================
// datapath shape
`define DADC_WORD_W        10
`define DADC_PIPE_LAT      5
`define DADC_FIFO_DEPTH    8
`define DADC_RECOVER_CYC   10

// ==========================================
// register map, byte addresses on apb
`define DADC_ADDR_W        8
`define DADC_CTRL_OFS      8'h00
`define DADC_STAT_OFS      8'h04
`define DADC_CTRL_RST      4'h0

// ==========================================
// control fields
`define DADC_CTRL_OVR_BIT  0
`define DADC_CTRL_M2_BIT   1
`define DADC_CTRL_M1_BIT   2
`define DADC_CTRL_FMT_BIT  3
`define DADC_CTRL_W        4

`endif

// File: pkg/dadc_pkg.sv
package dadc_pkg;

    // ==========================================
    // operating option chosen by the two mode pins
    typedef enum logic [1:0] {
        MODE_PD_ALL,
        MODE_PD_B,
        MODE_NORMAL,
        MODE_ALIGN
    } dadc_mode_t;

endpackage

// File: dv/dadc_capture_model.sv
`include "dadc_defs.svh"

// ==========================================
// capture latch standing behind one output channel
module dadc_capture_model #(
    parameter int W = `DADC_WORD_W
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] dout,
    input  wire logic         dout_oe_n,
    input  wire logic         clkout,
    input  wire logic         valid,
    output logic              cap,
    output logic [W-1:0]      cap_word,
    output logic [15:0]       cap_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [W-1:0] held;
    logic [W-1:0] pin;
    logic         ck_q;

    // released lines float
    // a floating bus reads as the inverse of the last word, so stale data never matches
    assign pin = dout_oe_n ? ~held : dout;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held     <= '0;
            ck_q     <= 1'b0;
            cap      <= 1'b0;
            cap_word <= '0;
            cap_cnt  <= '0;
        end else begin
            ck_q <= clkout;
            cap  <= 1'b0;
            if (!dout_oe_n) begin
                held <= dout;
            end
            // words that come before valid are thrown away
            if (valid && ck_q && !clkout) begin
                cap      <= 1'b1;
                cap_word <= pin;
                cap_cnt  <= cap_cnt + 16'h1;
            end
        end
    end
endmodule

// File: dv/dual_adc_output_mode_control_bench.sv
`include "dadc_defs.svh"

// ==========================================
// self-checking bench for the output staging block
module dual_adc_output_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int W = `DADC_WORD_W;
    typedef struct {logic [15:0] idx; logic [W-1:0] word;} dadc_note_t;
    typedef struct {logic [31:0] mask; logic [31:0] val; logic err;} dadc_rsp_t;

    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         enc = 1'b0;
    logic [3:0]   ecnt = 4'h0;
    logic         fmt = 1'b0;
    logic         m1 = 1'b1;
    logic         m2 = 1'b0;
    logic [W-1:0] sa_d = '0;
    logic [W-1:0] sb_d = '0;
    logic         sa_v = 1'b0;
    logic         sb_v = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready, pslverr, sa_r, sb_r, oe_a, oe_b, ck_a, ck_b, v_a, v_b, cap_a, cap_b;
    logic [W-1:0] da, db, wa, wb;
    logic [15:0]  cnt_a, cnt_b;
    logic [31:0]  lfsr = 32'hc13b;
    int           miscompares = 0;
    int           samples_checked = 0;
    dadc_note_t   qa[$];
    dadc_note_t   qb[$];
    dadc_rsp_t    qp[$];

    always #20 clk = ~clk;

    // one slow encode clock shared by both channels, twelve system cycles a sample
    // rate scaled to the system clock: the design only ever sees encode edges
    always @(posedge clk) begin
        ecnt <= (ecnt == 4'hb) ? 4'h0 : ecnt + 4'h1;
        enc  <= (ecnt < 4'h6);
    end

    dadc_top i_dadc_top (
        .clk, .rstn, .ce(1'b1), .enc_a(enc), .enc_b(enc), .format_select(fmt),
        .mode_pin_one(m1), .mode_pin_two(m2), .smp_a_data(sa_d), .smp_a_valid(sa_v),
        .smp_a_ready(sa_r), .smp_b_data(sb_d), .smp_b_valid(sb_v), .smp_b_ready(sb_r),
        .dout_a(da), .dout_a_oe_n(oe_a), .dout_b(db), .dout_b_oe_n(oe_b),
        .clkout_a(ck_a), .clkout_b(ck_b), .valid_a(v_a), .valid_b(v_b),
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
    );
    dadc_capture_model i_dadc_capture_model_a (
        .clk, .rstn, .dout(da), .dout_oe_n(oe_a), .clkout(ck_a), .valid(v_a),
        .cap(cap_a), .cap_word(wa), .cap_cnt(cnt_a)
    );
    dadc_capture_model i_dadc_capture_model_b (
        .clk, .rstn, .dout(db), .dout_oe_n(oe_b), .clkout(ck_b), .valid(v_b),
        .cap(cap_b), .cap_word(wb), .cap_cnt(cnt_b)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic conclude();
        $display("%0d checks made, %0d mismatches", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH at %0t: %0s", $time, msg);
        end
    endtask

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            check(1'b0, "wait ran out");
            conclude();
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] v, input logic e);
        int n;
        qp.push_back('{m, v, e});
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        bound(n, 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_cap();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cap_a !== 1'b1 && n < 400);
        bound(n, 400);
    endtask

    // pins move just after an encode fall, so no rise is half seen
    task automatic set_pins(input logic o, input logic t, input logic f, input int s);
        for (int i = 0; i < 12 && ecnt !== 4'h7; i++) @(posedge clk);
        m1  <= o;
        m2  <= t;
        fmt <= f;
        repeat (s) @(posedge clk);
    endtask

    // each word enters just before an encode rise; aligned b loads at the fall that clocks capture
    task automatic stream(input int n, input logic b_on);
        for (int i = 0; i < n; i++) begin
            wait_cap();
            lfsr = lfsr_next(lfsr);
            sa_d <= lfsr[9:0];
            sb_d <= lfsr[25:16];
            sa_v <= 1'b1;
            sb_v <= b_on;
            qa.push_back('{cnt_a + 16'd6, lfsr[9:0] ^ {fmt, 9'h0}});
            if (b_on) qb.push_back('{cnt_b + 16'd6, lfsr[25:16] ^ {fmt, 9'h0}});
            @(posedge clk);
            sa_v <= 1'b0;
            sb_v <= 1'b0;
        end
        repeat (8) wait_cap();
        check(qa.size() == 0 && qb.size() == 0, "words missing at outputs");
        $display("stream of %0d words done", n);
    endtask

    task automatic match(ref dadc_note_t q[$], input logic [15:0] c, input logic [W-1:0] w);
        if (q.size() > 0 && q[0].idx <= c) begin
            check(q[0].idx === c && q[0].word === w, "output word or its timing");
            void'(q.pop_front());
        end
    endtask

    // ==========================================
    // result watchers
    always @(posedge clk) begin
        if (cap_a === 1'b1) match(qa, cnt_a, wa);
        if (cap_b === 1'b1) match(qb, cnt_b, wb);
        if (pready === 1'b1 && psel === 1'b1 && qp.size() > 0) begin
            check((prdata & qp[0].mask) === qp[0].val && pslverr === qp[0].err, "apb answer");
            void'(qp.pop_front());
        end
    end

    // ==========================================
    // main sequence
    initial begin
        int   k;
        int   kb;
        logic prev;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, `DADC_CTRL_OFS, 32'h0, 32'hf, 32'h0, 1'b0);
        apb(1'b1, `DADC_CTRL_OFS, 32'hf, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `DADC_CTRL_OFS, 32'h0, 32'hf, 32'hf, 1'b0);
        apb(1'b0, `DADC_STAT_OFS, 32'h0, 32'h303, 32'h303, 1'b0);
        apb(1'b1, `DADC_CTRL_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
        apb(1'b1, `DADC_STAT_OFS, 32'h3ff, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h08, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b0, `DADC_STAT_OFS, 32'h0, 32'h3, 32'h2, 1'b0);
        $display("register test done");
        for (int f = 0; f < 2; f++) begin
            set_pins(1'b1, 1'b0, f[0], 6);
            stream(12, 1'b1);
        end
        set_pins(1'b1, 1'b1, 1'b0, 6);
        stream(12, 1'b1);
        set_pins(1'b0, 1'b1, 1'b1, 6);
        check(oe_b === 1'b1 && oe_a === 1'b0 && v_b === 1'b0, "b not released");
        stream(12, 1'b0);
        set_pins(1'b0, 1'b0, 1'b0, 6);
        check(oe_a === 1'b1 && oe_b === 1'b1 && v_a === 1'b0, "outputs not released");
        // stopped channels never drain, so each buffer must refuse at full depth
        sa_v <= 1'b1;
        sb_v <= 1'b1;
        k = 0;
        kb = 0;
        repeat (16) begin
            @(posedge clk);
            if (sa_r === 1'b1) k++;
            if (sb_r === 1'b1) kb++;
        end
        sa_v <= 1'b0;
        sb_v <= 1'b0;
        check(k == `DADC_FIFO_DEPTH, "buffer depth a");
        check(kb == `DADC_FIFO_DEPTH, "buffer depth b");
        set_pins(1'b1, 1'b0, 1'b0, 0);
        k = 0;
        prev = ck_a;
        for (int i = 0; i < 400 && v_a !== 1'b1; i++) begin
            @(posedge clk);
            if (ck_a === 1'b1 && prev === 1'b0) k++;
            prev = ck_a;
        end
        check(k == `DADC_RECOVER_CYC, "recovery length");
        apb(1'b0, `DADC_STAT_OFS, 32'h0, 32'h30, 32'h30, 1'b0);
        $display("power-down test done");
        stream(6, 1'b1);
        conclude();
    end
endmodule
